// *** ipg_ch_if.sv ***
// settings carried from the register bank to a channel decoder
`timescale 1ns/1ps
interface ipg_ch_if;
   logic [4:0] vol;
   logic [1:0] mode;
   logic cmr_en;
   modport bank (output vol, output mode, output cmr_en);
   modport dec (input vol, input mode, input cmr_en);
endinterface

// *** ipg_gain_dec.sv ***
// per-channel volume code to gain decoder
`timescale 1ns/1ps
module ipg_gain_dec
   import ipg_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   ipg_ch_if.dec ch,
   output logic signed [9:0] gain_db10_o,
   output logic cmr_active_o,
   output logic code_bad_o
);
   logic signed [9:0] line_db10;
   logic signed [9:0] mic_db10;
   logic signed [9:0] gain_next;

   always_comb begin
      unique case (ch.vol)
         5'h00: line_db10 = -10'sd15;
         5'h01: line_db10 = -10'sd13;
         5'h02: line_db10 = -10'sd10;
         5'h03: line_db10 = -10'sd7;
         5'h04: line_db10 = -10'sd7;
         5'h05: line_db10 = 10'sd0;
         5'h06: line_db10 = 10'sd3;
         5'h07: line_db10 = 10'sd7;
         5'h08: line_db10 = 10'sd10;
         5'h09: line_db10 = 10'sd14;
         5'h0A: line_db10 = 10'sd18;
         5'h0B: line_db10 = 10'sd23;
         5'h0C: line_db10 = 10'sd27;
         5'h0D: line_db10 = 10'sd32;
         5'h0E: line_db10 = 10'sd37;
         5'h0F: line_db10 = 10'sd42;
         5'h10: line_db10 = 10'sd48;
         5'h11: line_db10 = 10'sd54;
         5'h12: line_db10 = 10'sd60;
         5'h13: line_db10 = 10'sd67;
         5'h14: line_db10 = 10'sd75;
         5'h15: line_db10 = 10'sd83;
         5'h16: line_db10 = 10'sd92;
         5'h17: line_db10 = 10'sd102;
         5'h18: line_db10 = 10'sd114;
         5'h19: line_db10 = 10'sd127;
         5'h1A: line_db10 = 10'sd143;
         5'h1B: line_db10 = 10'sd162;
         5'h1C: line_db10 = 10'sd192;
         5'h1D: line_db10 = 10'sd223;
         5'h1E: line_db10 = 10'sd252;
         5'h1F: line_db10 = 10'sd283;
      endcase
   end

   always_comb begin
      // codes at and above the saturation code all sit at the top step
      if (ch.vol >= IPG_MIC_SAT_CODE) begin
         mic_db10 = IPG_MIC_MAX_DB10;
      end else if (ch.vol == 5'h00) begin
         mic_db10 = IPG_MIC_BASE_DB10 - IPG_MIC_STEP_DB10;
      end else begin
         mic_db10 = 10'(IPG_MIC_BASE_DB10 + IPG_MIC_STEP_DB10 * $signed({5'h00, ch.vol - 5'h01}));
      end
   end

   always_comb begin
      unique case (ipg_mode_e'(ch.mode))
         IPG_MODE_SE: gain_next = 10'(line_db10 + IPG_SE_EXTRA_DB10);
         IPG_MODE_DLINE: gain_next = line_db10;
         IPG_MODE_DMIC: gain_next = mic_db10;
         IPG_MODE_RSVD: gain_next = line_db10;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         gain_db10_o <= 10'sd60;
         cmr_active_o <= 1'b0;
         code_bad_o <= 1'b0;
      end else begin
         gain_db10_o <= gain_next;
         cmr_active_o <= ch.cmr_en && (ch.mode == IPG_MODE_DLINE);
         // zero code in mic mode is a software error; flagged, not blocked
         code_bad_o <= (ch.mode == IPG_MODE_DMIC) && (ch.vol == 5'h00);
      end
   end
endmodule

// *** ipg_pkg.sv ***
// shared constants and types for the input gain control block
package ipg_pkg;
   localparam logic [7:0] IPG_ADDR_PWR = 8'h0C;
   localparam logic [7:0] IPG_ADDR_LGAIN = 8'h2C;
   localparam logic [7:0] IPG_ADDR_RGAIN = 8'h2D;
   localparam logic [7:0] IPG_ADDR_LCFG = 8'h2E;
   localparam logic [7:0] IPG_ADDR_RCFG = 8'h2F;
   localparam int IPG_MUTE_BIT = 7;
   localparam int IPG_CMR_BIT = 6;
   localparam int IPG_VOL_LSB = 0;
   localparam int IPG_VOL_W = 5;
   localparam int IPG_SELN_LSB = 4;
   localparam int IPG_SELP_LSB = 2;
   localparam int IPG_MODE_LSB = 0;
   localparam int IPG_LPWR_BIT = 1;
   localparam int IPG_RPWR_BIT = 0;
   localparam logic [4:0] IPG_VOL_RST = 5'h05;
   localparam logic IPG_MUTE_RST = 1'b1;
   localparam logic IPG_CMR_RST = 1'b1;
   localparam logic [1:0] IPG_SELN_RST = 2'h0;
   localparam logic [1:0] IPG_SELP_RST = 2'h1;
   localparam logic [1:0] IPG_PWR_RST = 2'h0;
   localparam logic [4:0] IPG_MIC_SAT_CODE = 5'h07;
   // gain in tenths of a dB, signed
   localparam logic signed [9:0] IPG_MIC_BASE_DB10 = 10'sd120;
   localparam logic signed [9:0] IPG_MIC_STEP_DB10 = 10'sd30;
   localparam logic signed [9:0] IPG_MIC_MAX_DB10 = 10'sd300;
   localparam logic signed [9:0] IPG_SE_EXTRA_DB10 = 10'sd60;
   typedef enum logic [1:0] {
      IPG_MODE_SE = 2'b00,
      IPG_MODE_DLINE = 2'b01,
      IPG_MODE_DMIC = 2'b10,
      IPG_MODE_RSVD = 2'b11
   } ipg_mode_e;
endpackage

// *** ipg_top.sv ***
// input gain control register bank and amplifier control outputs
`timescale 1ns/1ps
module ipg_top
   import ipg_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic [4:0] left_gain_code_o,
   output logic [4:0] right_gain_code_o,
   output logic [1:0] left_mode_o,
   output logic [1:0] right_mode_o,
   output logic left_amp_silence_o,
   output logic right_amp_silence_o,
   output logic left_common_reject_on_o,
   output logic right_common_reject_on_o,
   output logic left_amp_power_on_o,
   output logic right_amp_power_on_o,
   output logic signed [9:0] left_gain_db10_o,
   output logic signed [9:0] right_gain_db10_o,
   output logic left_cmr_active_o,
   output logic right_cmr_active_o,
   output logic left_code_bad_o,
   output logic right_code_bad_o
);
   logic [4:0] left_vol_reg;
   logic [4:0] right_gain_code_reg;
   logic left_mute_reg;
   logic right_mute_reg;
   logic left_cmr_reg;
   logic right_cmr_reg;
   logic [1:0] left_seln_reg;
   logic [1:0] right_seln_reg;
   logic [1:0] left_selp_reg;
   logic [1:0] right_selp_reg;
   logic [1:0] left_mode_reg;
   logic [1:0] right_mode_reg;
   logic [1:0] pwr_reg;
   logic [15:0] rdata_next;

   ipg_ch_if lch ();
   ipg_ch_if rch ();

   assign lch.vol = left_vol_reg;
   assign lch.mode = left_mode_reg;
   assign lch.cmr_en = left_cmr_reg;
   assign rch.vol = right_gain_code_reg;
   assign rch.mode = right_mode_reg;
   assign rch.cmr_en = right_cmr_reg;

   // gain registers: volume and mute
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         left_vol_reg <= IPG_VOL_RST;
         right_gain_code_reg <= IPG_VOL_RST;
         left_mute_reg <= IPG_MUTE_RST;
         right_mute_reg <= IPG_MUTE_RST;
      end else if (wr_i) begin
         if (addr_i == IPG_ADDR_LGAIN) begin
            left_vol_reg <= wdata_i[IPG_VOL_LSB +: IPG_VOL_W];
            left_mute_reg <= wdata_i[IPG_MUTE_BIT];
         end
         if (addr_i == IPG_ADDR_RGAIN) begin
            right_gain_code_reg <= wdata_i[IPG_VOL_LSB +: IPG_VOL_W];
            right_mute_reg <= wdata_i[IPG_MUTE_BIT];
         end
      end
   end

   // config registers: common-mode enable, pin selects, mode
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         left_cmr_reg <= IPG_CMR_RST;
         right_cmr_reg <= IPG_CMR_RST;
         left_seln_reg <= IPG_SELN_RST;
         right_seln_reg <= IPG_SELN_RST;
         left_selp_reg <= IPG_SELP_RST;
         right_selp_reg <= IPG_SELP_RST;
         left_mode_reg <= IPG_MODE_SE;
         right_mode_reg <= IPG_MODE_SE;
      end else if (wr_i) begin
         // all mode codes stored as written, reserved one too, so readback matches
         if (addr_i == IPG_ADDR_LCFG) begin
            left_cmr_reg <= wdata_i[IPG_CMR_BIT];
            left_seln_reg <= wdata_i[IPG_SELN_LSB +: 2];
            left_selp_reg <= wdata_i[IPG_SELP_LSB +: 2];
            left_mode_reg <= wdata_i[IPG_MODE_LSB +: 2];
         end
         if (addr_i == IPG_ADDR_RCFG) begin
            right_cmr_reg <= wdata_i[IPG_CMR_BIT];
            right_seln_reg <= wdata_i[IPG_SELN_LSB +: 2];
            right_selp_reg <= wdata_i[IPG_SELP_LSB +: 2];
            right_mode_reg <= wdata_i[IPG_MODE_LSB +: 2];
         end
      end
   end

   // power register
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pwr_reg <= IPG_PWR_RST;
      end else if (wr_i && addr_i == IPG_ADDR_PWR) begin
         pwr_reg <= {wdata_i[IPG_LPWR_BIT], wdata_i[IPG_RPWR_BIT]};
      end
   end

   always_comb begin
      rdata_next = 16'h0000;
      unique case (addr_i)
         IPG_ADDR_PWR: rdata_next = {14'h0000, pwr_reg};
         IPG_ADDR_LGAIN: rdata_next = {8'h00, left_mute_reg, 2'h0, left_vol_reg};
         IPG_ADDR_RGAIN: rdata_next = {8'h00, right_mute_reg, 2'h0, right_gain_code_reg};
         IPG_ADDR_LCFG: rdata_next = {9'h000, left_cmr_reg, left_seln_reg, left_selp_reg, left_mode_reg};
         IPG_ADDR_RCFG: rdata_next = {9'h000, right_cmr_reg, right_seln_reg, right_selp_reg, right_mode_reg};
         default: rdata_next = 16'h0000;
      endcase
   end

   // read data stand for one cycle after each cycle of rd_i, zero otherwise
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= rd_i ? rdata_next : 16'h0000;
      end
   end

   // control outputs mirror registers one cycle later
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         left_gain_code_o <= IPG_VOL_RST;
         right_gain_code_o <= IPG_VOL_RST;
         left_mode_o <= IPG_MODE_SE;
         right_mode_o <= IPG_MODE_SE;
         left_amp_silence_o <= IPG_MUTE_RST;
         right_amp_silence_o <= IPG_MUTE_RST;
         left_common_reject_on_o <= IPG_CMR_RST;
         right_common_reject_on_o <= IPG_CMR_RST;
         left_amp_power_on_o <= 1'b0;
         right_amp_power_on_o <= 1'b0;
      end else begin
         left_gain_code_o <= left_vol_reg;
         right_gain_code_o <= right_gain_code_reg;
         left_mode_o <= left_mode_reg;
         right_mode_o <= right_mode_reg;
         left_amp_silence_o <= left_mute_reg;
         right_amp_silence_o <= right_mute_reg;
         left_common_reject_on_o <= left_cmr_reg;
         right_common_reject_on_o <= right_cmr_reg;
         left_amp_power_on_o <= pwr_reg[1];
         right_amp_power_on_o <= pwr_reg[0];
      end
   end

   ipg_gain_dec u_ldec (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .ch(lch.dec),
      .gain_db10_o(left_gain_db10_o),
      .cmr_active_o(left_cmr_active_o),
      .code_bad_o(left_code_bad_o)
   );

   ipg_gain_dec u_rdec (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .ch(rch.dec),
      .gain_db10_o(right_gain_db10_o),
      .cmr_active_o(right_cmr_active_o),
      .code_bad_o(right_code_bad_o)
   );

   sequence s_lgain_wr;
      wr_i && addr_i == IPG_ADDR_LGAIN;
   endsequence

   sequence s_rgain_wr;
      wr_i && addr_i == IPG_ADDR_RGAIN;
   endsequence

   sequence s_lcfg_wr;
      wr_i && addr_i == IPG_ADDR_LCFG;
   endsequence

   sequence s_rcfg_wr;
      wr_i && addr_i == IPG_ADDR_RCFG;
   endsequence

   sequence s_pwr_wr;
      wr_i && addr_i == IPG_ADDR_PWR;
   endsequence

   property p_vol_reset;
      @(posedge core_clk_i) srst_i |=> left_vol_reg == 5'h05 && right_gain_code_reg == 5'h05;
   endproperty
   a_vol_reset: assert property (p_vol_reset) else $error("volume reset value wrong");

   property p_mute_reset;
      @(posedge core_clk_i) srst_i |=> left_mute_reg && right_mute_reg && left_cmr_reg && !pwr_reg[1];
   endproperty
   a_mute_reset: assert property (p_mute_reset) else $error("mute/cmr/power reset wrong");

   property p_lvol_out;
      @(posedge core_clk_i) disable iff (srst_i)
         s_lgain_wr |=> ##1 left_gain_code_o == $past(wdata_i[4:0], 2);
   endproperty
   a_lvol_out: assert property (p_lvol_out) else $error("left volume not at output");

   property p_lmute_out;
      @(posedge core_clk_i) disable iff (srst_i)
         s_lgain_wr |=> ##1 left_amp_silence_o == $past(wdata_i[7], 2);
   endproperty
   a_lmute_out: assert property (p_lmute_out) else $error("left mute not at output");

   property p_rwr_keeps_left;
      @(posedge core_clk_i) disable iff (srst_i)
         wr_i && addr_i == IPG_ADDR_RGAIN |=> $stable(left_vol_reg) && $stable(left_mute_reg);
   endproperty
   a_rwr_keeps_left: assert property (p_rwr_keeps_left) else $error("right write disturbed left");

   property p_cmr_only_dline;
      @(posedge core_clk_i) disable iff (srst_i)
         ##1 left_cmr_active_o |-> $past(left_mode_reg) == IPG_MODE_DLINE && $past(left_cmr_reg);
   endproperty
   a_cmr_only_dline: assert property (p_cmr_only_dline) else $error("cmr active outside diff line");

   property p_mic_sat;
      @(posedge core_clk_i) disable iff (srst_i)
         left_mode_reg == IPG_MODE_DMIC && left_vol_reg >= 5'h07 |=> left_gain_db10_o == 10'sd300;
   endproperty
   a_mic_sat: assert property (p_mic_sat) else $error("mic gain not saturated");

   property p_mic_base;
      @(posedge core_clk_i) disable iff (srst_i)
         right_mode_reg == IPG_MODE_DMIC && right_gain_code_reg == 5'h01 |=> right_gain_db10_o == 10'sd120;
   endproperty
   a_mic_base: assert property (p_mic_base) else $error("mic base gain wrong");

   property p_se_extra;
      @(posedge core_clk_i) disable iff (srst_i)
         left_mode_reg == IPG_MODE_SE && left_vol_reg == 5'h1F |=> left_gain_db10_o == 10'sd343;
   endproperty
   a_se_extra: assert property (p_se_extra) else $error("single-ended extra gain missing");

   property p_line_ends;
      @(posedge core_clk_i) disable iff (srst_i)
         right_mode_reg == IPG_MODE_DLINE && right_gain_code_reg == 5'h00 |=> right_gain_db10_o == -10'sd15;
   endproperty
   a_line_ends: assert property (p_line_ends) else $error("line code zero gain wrong");

   property p_pwr_out;
      @(posedge core_clk_i) disable iff (srst_i)
         wr_i && addr_i == IPG_ADDR_PWR |=> ##1 left_amp_power_on_o == $past(wdata_i[1], 2);
   endproperty
   a_pwr_out: assert property (p_pwr_out) else $error("left power enable wrong");

   property p_bad_code;
      @(posedge core_clk_i) disable iff (srst_i)
         left_mode_reg == IPG_MODE_DMIC && left_vol_reg == 5'h00 |=> left_code_bad_o;
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("invalid mic code not flagged");

   property p_cmr_reg;
      @(posedge core_clk_i) disable iff (srst_i)
         wr_i && addr_i == IPG_ADDR_LCFG |=> ##1 left_common_reject_on_o == $past(wdata_i[6], 2);
   endproperty
   a_cmr_reg: assert property (p_cmr_reg) else $error("left cmr enable wrong");

   property p_rvol_out;
      @(posedge core_clk_i) disable iff (srst_i)
         s_rgain_wr |=> ##1 right_gain_code_o == $past(wdata_i[4:0], 2);
   endproperty
   a_rvol_out: assert property (p_rvol_out) else $error("right volume not at output");

   property p_rmute_out;
      @(posedge core_clk_i) disable iff (srst_i)
         s_rgain_wr |=> ##1 right_amp_silence_o == $past(wdata_i[7], 2);
   endproperty
   a_rmute_out: assert property (p_rmute_out) else $error("right mute not at output");

   property p_lwr_keeps_right;
      @(posedge core_clk_i) disable iff (srst_i)
         s_lgain_wr |=> $stable(right_gain_code_reg) && $stable(right_mute_reg);
   endproperty
   a_lwr_keeps_right: assert property (p_lwr_keeps_right) else $error("left write disturbed right");

   property p_rcmr_reg;
      @(posedge core_clk_i) disable iff (srst_i)
         s_rcfg_wr |=> ##1 right_common_reject_on_o == $past(wdata_i[6], 2);
   endproperty
   a_rcmr_reg: assert property (p_rcmr_reg) else $error("right cmr enable wrong");

   property p_lmode_out;
      @(posedge core_clk_i) disable iff (srst_i)
         s_lcfg_wr |=> ##1 left_mode_o == $past(wdata_i[1:0], 2);
   endproperty
   a_lmode_out: assert property (p_lmode_out) else $error("left mode not at output");

   property p_rpwr_out;
      @(posedge core_clk_i) disable iff (srst_i)
         s_pwr_wr |=> ##1 right_amp_power_on_o == $past(wdata_i[0], 2);
   endproperty
   a_rpwr_out: assert property (p_rpwr_out) else $error("right power enable wrong");

   property p_right_reset;
      @(posedge core_clk_i) srst_i |=> right_mute_reg && right_cmr_reg && !pwr_reg[0];
   endproperty
   a_right_reset: assert property (p_right_reset) else $error("right reset values wrong");

   property p_cmr_on_dline;
      @(posedge core_clk_i) disable iff (srst_i)
         left_mode_reg == IPG_MODE_DLINE && left_cmr_reg |=> left_cmr_active_o;
   endproperty
   a_cmr_on_dline: assert property (p_cmr_on_dline) else $error("cmr not active in diff line");

   property p_line_top;
      @(posedge core_clk_i) disable iff (srst_i)
         left_mode_reg == IPG_MODE_DLINE && left_vol_reg == 5'h1F |=> left_gain_db10_o == 10'sd283;
   endproperty
   a_line_top: assert property (p_line_top) else $error("line top gain wrong");

   property p_mic_step;
      @(posedge core_clk_i) disable iff (srst_i)
         right_mode_reg == IPG_MODE_DMIC && right_gain_code_reg == 5'h04 |=> right_gain_db10_o == 10'sd210;
   endproperty
   a_mic_step: assert property (p_mic_step) else $error("mic step gain wrong");

   property p_bad_clear;
      @(posedge core_clk_i) disable iff (srst_i)
         !(left_mode_reg == IPG_MODE_DMIC && left_vol_reg == 5'h00) |=> !left_code_bad_o;
   endproperty
   a_bad_clear: assert property (p_bad_clear) else $error("mic code flag raised wrongly");

   property p_rd_lgain;
      @(posedge core_clk_i) disable iff (srst_i)
         rd_i && addr_i == IPG_ADDR_LGAIN |=> rdata_o == {8'h00, $past(left_mute_reg), 2'h0, $past(left_vol_reg)};
   endproperty
   a_rd_lgain: assert property (p_rd_lgain) else $error("left gain readback wrong");
endmodule

// *** ipg_top_test.sv ***
// self-checking testbench for the input gain control register bank
`timescale 1ns/1ps
module ipg_top_test;
   import ipg_pkg::*;
   logic core_clk_i;
   logic srst_i;
   logic [7:0] addr_i;
   logic [15:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [15:0] rdata_o;
   logic [4:0] lcode, rcode;
   logic [1:0] lmode, rmode;
   logic lsil, rsil, lcm, rcm, lpwr, rpwr, lact, ract, lbad, rbad;
   logic signed [9:0] lgain, rgain;
   int num_errors;
   int checked;
   logic [15:0] rd_val;
   // line table in tenths of a dB, codes 0 to 31
   int line_tab[32] = '{-15, -13, -10, -7, -7, 0, 3, 7, 10, 14, 18, 23, 27, 32, 37, 42,
                        48, 54, 60, 67, 75, 83, 92, 102, 114, 127, 143, 162, 192, 223, 252, 283};

   ipg_top dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .left_gain_code_o(lcode), .right_gain_code_o(rcode),
      .left_mode_o(lmode), .right_mode_o(rmode), .left_amp_silence_o(lsil), .right_amp_silence_o(rsil),
      .left_common_reject_on_o(lcm), .right_common_reject_on_o(rcm), .left_amp_power_on_o(lpwr),
      .right_amp_power_on_o(rpwr), .left_gain_db10_o(lgain), .right_gain_db10_o(rgain),
      .left_cmr_active_o(lact), .right_cmr_active_o(ract), .left_code_bad_o(lbad), .right_code_bad_o(rbad));

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic wait_dec;
      repeat (3) @(posedge core_clk_i);
      #1;
   endtask

   task automatic chk_rst;
      reg_rd(IPG_ADDR_LGAIN, rd_val);
      chk(rd_val, 16'h0085, "left gain reset");
      reg_rd(IPG_ADDR_RGAIN, rd_val);
      chk(rd_val, 16'h0085, "right gain reset");
      reg_rd(IPG_ADDR_LCFG, rd_val);
      chk(rd_val, 16'h0044, "left cfg reset");
      reg_rd(IPG_ADDR_RCFG, rd_val);
      chk(rd_val, 16'h0044, "right cfg reset");
      reg_rd(IPG_ADDR_PWR, rd_val);
      chk(rd_val, 16'h0000, "power reset");
      chk({6'h00, lcode, rcode}, {6'h00, IPG_VOL_RST, IPG_VOL_RST}, "codes reset");
      chk({10'h000, lsil, rsil, lcm, rcm, lpwr, rpwr}, 16'h003C, "control bits reset");
      chk({12'h000, lmode, rmode}, 16'h0000, "modes reset");
      chk({6'h00, lgain}, 16'h003C, "left gain db reset");
      chk({12'h000, lact, ract, lbad, rbad}, 16'h0000, "status reset");
   endtask

   // every mode and every code on one channel, except code 0 in mic mode; the other channel stays muted
   task automatic sweep(input bit ch);
      logic [7:0] ga, ca;
      logic [9:0] g;
      int e;
      ga = ch ? IPG_ADDR_RGAIN : IPG_ADDR_LGAIN;
      ca = ch ? IPG_ADDR_RCFG : IPG_ADDR_LCFG;
      for (int m = 0; m < 4; m++) begin
         reg_wr(ca, {9'h000, 1'b1, 4'h0, m[1:0]});
         for (int c = 0; c < 32; c++) begin
            if (m == 2 && c == 0) continue;
            // gain changes only while muted, then unmute
            reg_wr(ga, {8'h00, 1'b1, 2'h0, c[4:0]});
            reg_wr(ga, {11'h000, c[4:0]});
            wait_dec();
            g = ch ? rgain : lgain;
            e = (m == 2) ? ((c >= 7) ? 300 : 120 + 30 * (c - 1)) : line_tab[c] + ((m == 0) ? 60 : 0);
            chk({6'h00, g}, {6'h00, 10'(e)}, "decoded gain");
            chk({11'h000, ch ? rcm : lcm, ch ? ract : lact, ch ? rbad : lbad, ch ? rmode : lmode},
                {11'h000, 1'b1, m == 1, 1'b0, m[1:0]}, "mode and cm");
            chk({14'h0000, ch ? rsil : lsil, ch ? lsil : rsil}, 16'h0001, "independent mute");
            chk({11'h000, ch ? rcode : lcode}, {11'h000, c[4:0]}, "code out");
         end
      end
      reg_wr(ga, 16'h0080);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge core_clk_i);
      num_errors++;
      $display("BAD t=%0t run limit reached", $time);
      summarize();
   end

   initial begin
      srst_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 16'h0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      num_errors = 0;
      checked = 0;
      repeat (16) @(posedge core_clk_i);
      srst_i <= 1'b0;
      chk_rst();
      reg_wr(IPG_ADDR_LGAIN, 16'h0080);
      sweep(1'b0);
      sweep(1'b1);
      // bits outside the fields read back as zero
      reg_wr(IPG_ADDR_LGAIN, 16'hFFFF);
      reg_rd(IPG_ADDR_LGAIN, rd_val);
      chk(rd_val, 16'h009F, "gain reg width");
      reg_wr(IPG_ADDR_LCFG, 16'hFFFF);
      reg_rd(IPG_ADDR_LCFG, rd_val);
      chk(rd_val, 16'h007F, "cfg reg width");
      // write reaches the output on the second edge, not before
      reg_wr(IPG_ADDR_LGAIN, 16'h001A);
      #1 chk({11'h000, lcode}, 16'h001F, "code too early");
      @(posedge core_clk_i);
      #1 chk({10'h000, lcode, lsil}, 16'h0034, "code update");
      // cm enable cleared in line mode turns common-mode rejection off on that side only
      reg_wr(IPG_ADDR_LCFG, 16'h0001);
      wait_dec();
      chk({12'h000, lcm, lact, rcm, ract}, 16'h0002, "cm off");
      reg_wr(IPG_ADDR_PWR, 16'hFFFF);
      repeat (2) @(posedge core_clk_i);
      #1 chk({14'h0000, lpwr, rpwr}, 16'h0003, "power both");
      reg_wr(IPG_ADDR_PWR, 16'h0002);
      reg_rd(IPG_ADDR_PWR, rd_val);
      chk({rd_val[15:2], lpwr, rpwr}, 16'h0002, "power left only");
      // unmapped place: writes ignored, reads zero
      reg_wr(8'h30, 16'hFFFF);
      reg_rd(8'h30, rd_val);
      chk(rd_val, 16'h0000, "unmapped read");
      reg_rd(IPG_ADDR_LGAIN, rd_val);
      chk(rd_val, 16'h001A, "gain after unmapped write");
      @(posedge core_clk_i);
      #1 chk(rdata_o, 16'h0000, "read data held too long");
      // deliberate misuse: zero code in mic mode must raise the flag
      reg_wr(IPG_ADDR_LGAIN, 16'h0080);
      reg_wr(IPG_ADDR_LCFG, 16'h0042);
      wait_dec();
      chk({5'h00, lbad, lgain}, 16'h045A, "mic code zero flag and gain");
      // second reset in mid-run restores every default
      @(posedge core_clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      srst_i <= 1'b0;
      chk_rst();
      summarize();
   end
endmodule
